// [rtl/sewts_pkg.sv]
// Purpose: Shared constants and types for the two-wire serial memory slave
// Assumes: Core clock of 200 MHz samples the serial pins
// Notes: Timing counts are derived from printed times
package sewts_pkg;
  localparam int unsigned CORE_MHZ = 200;
  localparam int unsigned WR_TIME_US = 5000;
  localparam int unsigned WR_CYCLES = WR_TIME_US * CORE_MHZ;
  localparam int unsigned WR_CNT_W = 20;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned PAGE_OFF_W = 7;
  localparam int unsigned PAGE_BYTES = 128;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam logic [3:0] BITS_PER_WORD = 4'h8;
  // Device-type code value is arbitrary
  localparam logic [3:0] DEV_TYPE_DEF = 4'h5;
  localparam logic [15:0] ADDR_RST = 16'h0000;

  typedef struct packed {
    logic [6:0] off;
    logic [7:0] data;
  } sewts_wbyte_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RX = 3'h1,
    ST_ACK = 3'h3,
    ST_TX = 3'h2,
    ST_MACK = 3'h6
  } sewts_state_t;

  typedef enum logic [1:0] {
    K_SEL = 2'h0,
    K_AH = 2'h1,
    K_AL = 2'h3,
    K_DAT = 2'h2
  } sewts_kind_t;

  typedef enum logic [1:0] {
    W_IDLE = 2'h0,
    W_WAIT = 2'h1,
    W_COPY = 2'h3,
    W_TIME = 2'h2
  } sewts_wst_t;
endpackage

// [rtl/sewts_fifo.sv]
// Purpose: Small synchronous FIFO with valid and ready on both sides
// Assumes: One clock domain
// Notes: Full and empty come from an occupancy count
`timescale 1ns/1ps
`default_nettype none
module sewts_fifo #(
  parameter int unsigned WIDTH = 15,
  parameter int unsigned DEPTH = 32
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // Drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wp_q, rp_q;
  logic [PW:0] cnt_q;
  logic push, pop;

  assign o_in_ready = (cnt_q != (PW+1)'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data = mem[rp_q];
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wp_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == PW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == PW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule // sewts_fifo
`default_nettype wire

// [rtl/sewts_top.sv]
// Purpose: Two-wire slave engine of a 64 KiB serial memory with timed writes
// Assumes: Serial pins are asynchronous and much slower than the core clock
// Notes: Pins pass two flops; all protocol work happens on detected edges
`timescale 1ns/1ps
`default_nettype none
// Operation
// [RQ1] SDA falling while SCL high is Start
// [RQ2] SDA rising while SCL high is Stop
// [RQ3] Data changes only while SCL low
// [RQ4] Eight-bit words, acknowledged on ninth clock
// [RQ5] Select byte: type code, chip bits, direction
// [RQ6] Chip bits must match pins to acknowledge
// [RQ7] Direction one reads, zero writes
// [RQ8] Byte write: two address bytes, data, Stop
// [RQ9] Stop starts timed write; device deaf meanwhile
// [RQ10] Page write accepts up to 128 bytes
// [RQ11] Only low seven address bits increment on write
// [RQ12] Extra bytes wrap and overwrite in page
// [RQ13] Select acknowledged only after write cycle ends
// [RQ14] Protect input high inhibits all writes
// [RQ15] Address counter holds last address plus one
// [RQ16] Read counter rolls over whole array
// [RQ17] Current read sends byte at counter
// [RQ18] Random read uses dummy write then restart
// [RQ19] Master acknowledge continues sequential read
// [RQ20] Start, nine clocks, Start, Stop resets protocol
// [RQ21] Standby at power-up and after idle Stop
// [RQ22] Sample on SCL rise, drive after fall
// [RQ23] SDA driven low only, open drain
// [RQ24] 512 pages of 128 bytes, 16-bit address
// [RQ25] High address byte first, MSB first
// [RQ26] Protected writes still acknowledged, no cycle
module sewts_top #(
  parameter int unsigned WR_CYCLES = sewts_pkg::WR_CYCLES,
  parameter logic [3:0] DEV_TYPE = sewts_pkg::DEV_TYPE_DEF
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // Serial bus
  input wire logic i_scl,
  input wire logic i_sda_in,
  output logic o_sda_out,
  output logic o_sda_oe,
  // Straps and protect
  input wire logic i_chip_select_bit_2,
  input wire logic i_chip_select_bit_1,
  input wire logic i_chip_select_bit_0,
  input wire logic i_write_protect,
  // Status
  output logic o_standby,
  output logic o_write_busy
);
  localparam int unsigned MEM_BYTES = 1 << sewts_pkg::ADDR_W;

  logic rst_m_q, rst_n;
  logic scl_m_q, scl_s_q, scl_p_q;
  logic sda_m_q, sda_s_q, sda_p_q;
  logic [2:0] cs_m_q, cs_s_q;
  logic wp_m_q, wp_s_q;
  logic scl_rise, scl_fall, start_det, stop_det;

  sewts_pkg::sewts_state_t st_q;
  sewts_pkg::sewts_kind_t kind_q;
  sewts_pkg::sewts_wst_t wst_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] sh_q;
  logic [15:0] addr_q;
  logic [8:0] wpage_q;
  logic rd_q, mack_q, pend_q, oe_q, sda_out_q, standby_q, busy_out_q;
  logic push_q;
  sewts_pkg::sewts_wbyte_t push_word_q, drain_word;
  logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [6:0] copy_idx_q;
  logic [19:0] timer_q;
  logic busy, pb_clr, commit_req;
  logic copy_last;

  logic [7:0] mem [MEM_BYTES];
  logic [7:0] pb_data [sewts_pkg::PAGE_BYTES];
  logic [sewts_pkg::PAGE_BYTES-1:0] pb_vld_q;
  logic [7:0] mem_rd;

  // Reset release through two flops
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_m_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_n <= rst_m_q;
    end
  end

  // Bus pin synchronisers; the third stage only serves edge detection
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_m_q <= i_scl;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= i_sda_in;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
    end
  end

  // Straps and protect change rarely but still cross into the core domain
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_m_q <= 3'h0;
      cs_s_q <= 3'h0;
      wp_m_q <= 1'b0;
      wp_s_q <= 1'b0;
    end else begin
      cs_m_q <= {i_chip_select_bit_2, i_chip_select_bit_1, i_chip_select_bit_0};
      cs_s_q <= cs_m_q;
      wp_m_q <= i_write_protect;
      wp_s_q <= wp_m_q;
    end
  end

  assign scl_rise = scl_s_q & ~scl_p_q;
  assign scl_fall = ~scl_s_q & scl_p_q;
  assign start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q; // [RQ1] [RQ3]
  assign stop_det = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q; // [RQ2] [RQ3]
  assign busy = (wst_q != sewts_pkg::W_IDLE);
  // Combinational array read; a macro with a registered port would need a lead cycle
  assign mem_rd = mem[addr_q]; // [RQ24]
  // A restart discards unwritten data, but never while a commit is copying
  assign pb_clr = start_det & ~busy;
  assign commit_req = stop_det & pend_q & ~wp_s_q; // [RQ9] [RQ14] [RQ26]
  // Last copy step; the sequencer and the valid map both end the commit here
  assign copy_last = (wst_q == sewts_pkg::W_COPY) &&
                     (copy_idx_q == 7'(sewts_pkg::PAGE_BYTES - 1));

  // Polls during a write cycle fail here, which is the busy answer
  function automatic logic sel_match(input logic [7:0] b, input logic [2:0] cs,
                                     input logic bsy);
    sel_match = (b[7:4] == DEV_TYPE) && (b[3:1] == cs) && !bsy; // [RQ5] [RQ6] [RQ13]
  endfunction

  // Protocol engine
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= sewts_pkg::ST_IDLE; // [RQ21]
      kind_q <= sewts_pkg::K_SEL;
      bit_cnt_q <= 4'h0;
      sh_q <= 8'h00;
      addr_q <= sewts_pkg::ADDR_RST;
      wpage_q <= 9'h000;
      rd_q <= 1'b0;
      mack_q <= 1'b1;
      pend_q <= 1'b0;
      oe_q <= 1'b0;
      push_q <= 1'b0;
      push_word_q <= '0;
    end else begin
      push_q <= 1'b0;
      if (start_det) begin
        // Also ends any half-done transfer, which is what the bus reset relies on
        st_q <= sewts_pkg::ST_RX; // [RQ20]
        kind_q <= sewts_pkg::K_SEL;
        bit_cnt_q <= 4'h0;
        oe_q <= 1'b0;
        pend_q <= 1'b0;
      end else if (stop_det) begin
        st_q <= sewts_pkg::ST_IDLE; // [RQ2] [RQ21]
        oe_q <= 1'b0;
        pend_q <= 1'b0;
      end else begin
        case (st_q)
          sewts_pkg::ST_RX: begin
            if (scl_rise && bit_cnt_q != sewts_pkg::BITS_PER_WORD) begin
              sh_q <= {sh_q[6:0], sda_s_q}; // [RQ22] [RQ25]
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (scl_fall && bit_cnt_q == sewts_pkg::BITS_PER_WORD) begin
              case (kind_q)
                sewts_pkg::K_SEL: begin
                  if (sel_match(sh_q, cs_s_q, busy)) begin
                    rd_q <= sh_q[0]; // [RQ7]
                    oe_q <= 1'b1; // [RQ4]
                    st_q <= sewts_pkg::ST_ACK;
                  end else begin
                    st_q <= sewts_pkg::ST_IDLE; // [RQ6]
                  end
                end
                sewts_pkg::K_AH: begin
                  addr_q[15:8] <= sh_q; // [RQ25]
                  oe_q <= 1'b1;
                  st_q <= sewts_pkg::ST_ACK;
                end
                sewts_pkg::K_AL: begin
                  addr_q[7:0] <= sh_q; // [RQ8] [RQ18]
                  // Page bit 7 comes from the byte just taken, not the old counter
                  wpage_q <= {addr_q[15:8], sh_q[7]}; // [RQ24]
                  oe_q <= 1'b1;
                  st_q <= sewts_pkg::ST_ACK;
                end
                default: begin
                  // A full buffer refuses the byte by withholding the acknowledge
                  if (fifo_in_ready) begin
                    push_q <= 1'b1;
                    push_word_q <= '{off: addr_q[6:0], data: sh_q};
                    addr_q[6:0] <= addr_q[6:0] + 7'h01; // [RQ11] [RQ12]
                    pend_q <= 1'b1; // [RQ10]
                    oe_q <= 1'b1;
                    st_q <= sewts_pkg::ST_ACK;
                  end else begin
                    st_q <= sewts_pkg::ST_IDLE;
                  end
                end
              endcase
            end
          end
          sewts_pkg::ST_ACK: begin
            if (scl_fall) begin
              if (kind_q == sewts_pkg::K_SEL && rd_q) begin
                sh_q <= {mem_rd[6:0], 1'b0}; // [RQ17]
                oe_q <= ~mem_rd[7]; // [RQ23]
                addr_q <= addr_q + 16'h0001; // [RQ15] [RQ16]
                bit_cnt_q <= 4'h1;
                st_q <= sewts_pkg::ST_TX;
              end else begin
                oe_q <= 1'b0;
                bit_cnt_q <= 4'h0;
                st_q <= sewts_pkg::ST_RX;
                case (kind_q)
                  sewts_pkg::K_SEL: kind_q <= sewts_pkg::K_AH;
                  sewts_pkg::K_AH: kind_q <= sewts_pkg::K_AL;
                  default: kind_q <= sewts_pkg::K_DAT;
                endcase
              end
            end
          end
          sewts_pkg::ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt_q == sewts_pkg::BITS_PER_WORD) begin
                oe_q <= 1'b0;
                mack_q <= 1'b1;
                st_q <= sewts_pkg::ST_MACK;
              end else begin
                oe_q <= ~sh_q[7]; // [RQ22] [RQ23]
                sh_q <= {sh_q[6:0], 1'b0};
                bit_cnt_q <= bit_cnt_q + 4'h1;
              end
            end
          end
          sewts_pkg::ST_MACK: begin
            if (scl_rise) begin
              mack_q <= sda_s_q;
            end else if (scl_fall) begin
              if (!mack_q) begin
                sh_q <= {mem_rd[6:0], 1'b0}; // [RQ19]
                oe_q <= ~mem_rd[7];
                addr_q <= addr_q + 16'h0001; // [RQ16]
                bit_cnt_q <= 4'h1;
                st_q <= sewts_pkg::ST_TX;
              end else begin
                st_q <= sewts_pkg::ST_IDLE; // [RQ17] [RQ19]
              end
            end
          end
          default: begin
            oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // Write-cycle sequencer: wait for the buffer to drain, copy, then stay deaf
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wst_q <= sewts_pkg::W_IDLE;
      copy_idx_q <= 7'h00;
      timer_q <= 20'h00000;
    end else begin
      case (wst_q)
        sewts_pkg::W_IDLE: begin
          if (commit_req) begin
            wst_q <= sewts_pkg::W_WAIT; // [RQ9]
          end
        end
        sewts_pkg::W_WAIT: begin
          if (!fifo_out_valid) begin
            copy_idx_q <= 7'h00;
            wst_q <= sewts_pkg::W_COPY;
          end
        end
        sewts_pkg::W_COPY: begin
          copy_idx_q <= copy_idx_q + 7'h01;
          if (copy_last) begin
            timer_q <= 20'h00000;
            wst_q <= sewts_pkg::W_TIME;
          end
        end
        default: begin
          // Programming window; selects keep failing until it runs out
          timer_q <= timer_q + 20'h00001;
          if (timer_q == 20'(WR_CYCLES - 1)) begin
            wst_q <= sewts_pkg::W_IDLE; // [RQ13] [RQ21]
          end
        end
      endcase
    end
  end

  // Array update only from a committed page
  always_ff @(posedge i_core_clk) begin
    if (wst_q == sewts_pkg::W_COPY && pb_vld_q[copy_idx_q]) begin
      mem[{wpage_q, copy_idx_q}] <= pb_data[copy_idx_q]; // [RQ24] [RQ12]
    end
  end

  // Page buffer: later bytes to the same offset replace earlier ones
  always_ff @(posedge i_core_clk) begin
    if (fifo_out_valid && fifo_out_ready) begin
      pb_data[drain_word.off] <= drain_word.data; // [RQ12]
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pb_vld_q <= '0;
    end else if (pb_clr || copy_last) begin
      pb_vld_q <= '0;
    end else if (fifo_out_valid && fifo_out_ready) begin
      pb_vld_q[drain_word.off] <= 1'b1;
    end
  end

  // Draining stalls during the copy so the page stays stable
  assign fifo_out_ready = (wst_q != sewts_pkg::W_COPY);

  sewts_fifo #(
    .WIDTH($bits(sewts_pkg::sewts_wbyte_t)),
    .DEPTH(sewts_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_core_clk),
    .i_rst_n(rst_n),
    .i_in_valid(push_q),
    .i_in_data(push_word_q),
    .o_in_ready(fifo_in_ready),
    .o_out_valid(fifo_out_valid),
    .o_out_data(drain_word),
    .i_out_ready(fifo_out_ready)
  );

  // Output flops
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_out_q <= 1'b0;
      standby_q <= 1'b1;
      busy_out_q <= 1'b0;
    end else begin
      sda_out_q <= 1'b0; // [RQ23]
      standby_q <= (st_q == sewts_pkg::ST_IDLE) && !busy; // [RQ21]
      busy_out_q <= busy;
    end
  end

  assign o_sda_out = sda_out_q;
  assign o_sda_oe = oe_q;
  assign o_standby = standby_q;
  assign o_write_busy = busy_out_q;
endmodule // sewts_top
`default_nettype wire

// [sim/sewts_top_sva.sv]
// Purpose: Bus and write-cycle assertions for the serial memory slave
// Assumes: Sees only the top ports; bus pins idle high
// Notes: Bind sits at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module sewts_top_sva #(
  parameter int unsigned WR_CYCLES = 50
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // Bus and protect
  input wire logic i_scl,
  input wire logic i_sda_in,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic i_write_protect,
  // Status
  input wire logic o_standby,
  input wire logic o_write_busy
);
  logic [31:0] busy_n_q;
  logic [7:0] since_stop_q;
  logic sda_q;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      busy_n_q <= 32'h0;
    end else begin
      busy_n_q <= o_write_busy ? busy_n_q + 32'h1 : 32'h0;
    end
  end
  always_ff @(posedge i_core_clk) begin
    sda_q <= i_sda_in;
  end
  // Saturates so a long idle bus never looks like a fresh Stop
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      since_stop_q <= 8'hff;
    end else if (i_scl && !sda_q && i_sda_in) begin
      since_stop_q <= 8'h0;
    end else if (since_stop_q != 8'hff) begin
      since_stop_q <= since_stop_q + 8'h1;
    end
  end
  property p_low_only; o_sda_oe |-> !o_sda_out; endproperty
  a_low_only: assert property (p_low_only) else $error("data driven high");
  property p_scl_low; $changed(o_sda_oe) |-> !$past(i_scl) && !$past(i_scl, 2); endproperty
  a_scl_low: assert property (p_scl_low) else $error("drive moved in clock high");
  property p_deaf; o_write_busy |-> !o_sda_oe; endproperty
  a_deaf: assert property (p_deaf) else $error("answer during write cycle");
  property p_busy_min; $rose(o_write_busy) |=> o_write_busy [*8]; endproperty
  a_busy_min: assert property (p_busy_min) else $error("write cycle cut short");
  property p_busy_len; $fell(o_write_busy) |-> busy_n_q >= WR_CYCLES; endproperty
  a_busy_len: assert property (p_busy_len) else $error("write cycle too short");
  property p_after_stop; $rose(o_write_busy) |-> since_stop_q < 8'h10; endproperty
  a_after_stop: assert property (p_after_stop) else $error("write cycle without Stop");
  property p_not_standby; o_write_busy && $past(o_write_busy) |-> !o_standby; endproperty
  a_not_standby: assert property (p_not_standby) else $error("standby while busy");
  property p_quiet; o_standby |-> !o_sda_oe; endproperty
  a_quiet: assert property (p_quiet) else $error("drive in standby");
  property p_protect; $rose(o_write_busy) |-> !$past(i_write_protect, 4); endproperty
  a_protect: assert property (p_protect) else $error("write cycle while protected");
  c_cycle: cover property ($rose(o_write_busy));
  c_ack: cover property ($rose(o_sda_oe));
  c_back: cover property ($rose(o_standby));
endmodule // sewts_top_sva
bind sewts_top sewts_top_sva #(.WR_CYCLES(WR_CYCLES)) chk_u (
  .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_scl(i_scl), .i_sda_in(i_sda_in),
  .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .i_write_protect(i_write_protect),
  .o_standby(o_standby), .o_write_busy(o_write_busy));
`default_nettype wire

// [sim/sewts_master_mdl.sv]
// Purpose: Behavioural two-wire bus master for the memory slave bench
// Assumes: Bench resolves the wire with a pull-up
// Notes: 48 ns bit period; data moves mid clock-low; clock idles high
`timescale 1ns/1ps
`default_nettype none
module sewts_master_mdl (
  // Bus lines
  output var logic o_scl,
  output var logic o_sda_low,
  input wire logic i_sda
);
  localparam time Q = 12;
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // Sample mid-high so a late answer still lands
  task automatic clk_bit(input logic b, output logic r);
    #Q o_sda_low = !b;
    #Q o_scl = 1'b1;
    #Q r = i_sda;
    #Q o_scl = 1'b0;
  endtask
  task automatic start();
    #Q o_sda_low = 1'b0;
    #Q o_scl = 1'b1;
    #Q o_sda_low = 1'b1;
    #Q o_scl = 1'b0;
  endtask
  task automatic stop();
    #Q o_sda_low = 1'b1;
    #Q o_scl = 1'b1;
    #Q o_sda_low = 1'b0;
    #Q;
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], r);
    clk_bit(1'b1, r);
    ack = !r;
  endtask
  task automatic rd_byte(input logic mack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, r);
      b[i] = r;
    end
    clk_bit(!mack, r);
  endtask
endmodule // sewts_master_mdl
`default_nettype wire

// [sim/sewts_top_bench.sv]
// Purpose: Self-checking bench for the two-wire memory slave
// Assumes: Master model drives the bus; straps drawn at random
// Notes: Short write cycle parameter keeps the run brief
`timescale 1ns/1ps
`default_nettype none
module sewts_top_bench;
  localparam int unsigned WRC = 50;
  localparam logic [3:0] DT = sewts_pkg::DEV_TYPE_DEF;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic scl;
  logic m_low;
  logic sda_out;
  logic sda_oe;
  logic [2:0] cs = 3'h0;
  logic wp = 1'b0;
  logic standby;
  logic busy;
  logic ack;
  logic [7:0] rb;
  logic [15:0] ptr;
  logic [15:0] ra;
  int rn;
  logic [7:0] exp_mem [logic [15:0]];
  int seed = 32'h2fa77844;
  int n_errors = 0;
  int total_checks = 0;
  wire logic sda_w = !(m_low || sda_oe);
  sewts_top #(.WR_CYCLES(WRC), .DEV_TYPE(DT)) dut_u (
    .i_core_clk(clk), .i_rstn(rstn), .i_scl(scl), .i_sda_in(sda_w),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_chip_select_bit_2(cs[2]),
    .i_chip_select_bit_1(cs[1]), .i_chip_select_bit_0(cs[0]),
    .i_write_protect(wp), .o_standby(standby), .o_write_busy(busy));
  sewts_master_mdl mdl_u (.o_scl(scl), .o_sda_low(m_low), .i_sda(sda_w));
  always #2.5 clk = ~clk;
  task automatic summarize();
    if (n_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask
  function automatic logic [7:0] sel(input logic rd, input logic [2:0] c);
    return {DT, c, rd};
  endfunction
  function automatic logic [15:0] wr_next(input logic [15:0] a);
    return {a[15:7], a[6:0] + 7'h1};
  endfunction
  // Fixed offset after the edge keeps the 12 ns bus steps off clock edges
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1.5;
  endtask
  task automatic wait_idle();
    int i;
    for (i = 0; i < 4000 && (busy !== 1'b0 || standby !== 1'b1); i++) cyc(1);
    if (i == 4000) begin
      n_errors++;
      summarize();
    end
  endtask
  task automatic wr_seq(input logic [15:0] a, input int n, input logic fin);
    logic [7:0] d;
    mdl_u.start();
    mdl_u.wr_byte(sel(1'b0, cs), ack);
    check(ack, 1'b1);
    mdl_u.wr_byte(a[15:8], ack);
    check(ack, 1'b1);
    mdl_u.wr_byte(a[7:0], ack);
    check(ack, 1'b1);
    repeat (n) begin
      d = 8'($random(seed));
      mdl_u.wr_byte(d, ack);
      check(ack, 1'b1);
      if (!wp) exp_mem[a] = d;
      a = wr_next(a);
    end
    ptr = a;
    if (fin) mdl_u.stop();
  endtask
  task automatic rd_seq(input int n);
    mdl_u.start();
    mdl_u.wr_byte(sel(1'b1, cs), ack);
    check(ack, 1'b1);
    for (int k = 0; k < n; k++) begin
      mdl_u.rd_byte(k < n - 1, rb);
      check(rb, exp_mem[ptr]);
      ptr = ptr + 16'h1;
    end
    mdl_u.stop();
  endtask
  initial begin
    #400us;
    n_errors++;
    summarize();
  end
  initial begin
    cs = 3'($random(seed));
    cyc(20);
    rstn = 1'b1;
    cyc(6);
    check({standby, busy, sda_oe}, 3'h4);
    for (int c = 1; c < 8; c++) begin
      mdl_u.start();
      mdl_u.wr_byte(sel(1'b0, cs ^ 3'(c)), ack);
      check(ack, 1'b0);
      mdl_u.stop();
    end
    mdl_u.start();
    mdl_u.wr_byte({~DT, cs, 1'b0}, ack);
    check(ack, 1'b0);
    mdl_u.stop();
    // 130 bytes from offset 0x7e: wraps in page, first two overwritten
    wr_seq({9'($random(seed)), 7'h7e}, 130, 1'b1);
    cyc(10);
    check(busy, 1'b1);
    mdl_u.start();
    mdl_u.wr_byte(sel(1'b0, cs), ack);
    check(ack, 1'b0);
    mdl_u.stop();
    wait_idle();
    rd_seq(128);
    wr_seq(16'hffff, 1, 1'b1);
    wait_idle();
    wr_seq(16'h0000, 1, 1'b1);
    wait_idle();
    wr_seq(16'hffff, 0, 1'b0);
    rd_seq(2);
    cyc(1);
    wp = 1'b1;
    wr_seq(16'h0000, 1, 1'b1);
    cyc(20);
    check(busy, 1'b0);
    cyc(1);
    wp = 1'b0;
    wr_seq(16'h0000, 0, 1'b0);
    rd_seq(1);
    repeat (3) begin
      ra = 16'($random(seed));
      ra[6] = 1'b0;
      rn = 1 + ($random(seed) & 7);
      wr_seq(ra, rn, 1'b1);
      wait_idle();
      wr_seq(ra, 0, 1'b0);
      rd_seq(rn);
    end
    mdl_u.start();
    repeat (9) mdl_u.clk_bit(1'b1, ack);
    mdl_u.start();
    mdl_u.stop();
    wr_seq(ra, 0, 1'b0);
    rd_seq(1);
    cyc(10);
    check(standby, 1'b1);
    summarize();
  end
endmodule // sewts_top_bench
`default_nettype wire
